// File: hw/eaic_top.sv
// Purpose: Error/alarm condition capture and two interrupt lines
// Assumes: Condition pulses come from logic on core_clk_i
// Notes:   Read data is registered, valid one cycle after a read
`timescale 1ns/1ps
`default_nettype none
`include "eaic_defines.svh"

module eaic_top
    import eaic_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                clk_en_i,
    input  wire eaic_cond_t          cond_pulse_i,
    input  wire eaic_req_s           reg_req_i,
    output logic [`EAIC_DW-1:0]      reg_rdata_o,
    output logic                     reg_rvalid_o,
    output logic [1:0]               fault_irq_line_o
);

    // ********************************************
    // Declarations
    // ********************************************
    eaic_cond_t  raw_condition_status;
    eaic_cond_t  wr_bits;
    eaic_line_s  line0;
    eaic_line_s  line1;
    logic        wr_set0;
    logic        wr_set1;
    logic        wr_clr0;
    logic        wr_clr1;
    logic        wr_dset;
    logic        wr_dclr;
    logic        wr_reev;
    logic        reev0;
    logic        reev1;
    logic [1:0]  reev_status;
    logic [`EAIC_DW-1:0] next_rdata;
    eaic_cond_t  unforce_condition_bits;

    // ********************************************
    // Write decode
    // ********************************************
    assign wr_bits = reg_req_i.wdata[`EAIC_NCOND-1:0];

    always_comb
    begin
        wr_set0 = 1'b0;
        wr_set1 = 1'b0;
        wr_clr0 = 1'b0;
        wr_clr1 = 1'b0;
        wr_dset = 1'b0;
        wr_dclr = 1'b0;
        wr_reev = 1'b0;
        if (reg_req_i.wr)
        begin
            unique case (reg_req_i.addr)
                `EAIC_OFF_SET0:  wr_set0 = 1'b1;
                `EAIC_OFF_SET1:  wr_set1 = 1'b1;
                `EAIC_OFF_CLR0:  wr_clr0 = 1'b1;
                `EAIC_OFF_CLR1:  wr_clr1 = 1'b1;
                `EAIC_OFF_DSET:  wr_dset = 1'b1;
                `EAIC_OFF_DCLR:  wr_dclr = 1'b1;
                `EAIC_OFF_REEVAL: wr_reev = 1'b1;
                default:         wr_reev = 1'b0;
            endcase
        end
    end

    // Line select; other codes are ignored
    // [RULE_14] Re-evaluate select
    assign reev0 = wr_reev && (reg_req_i.wdata[1:0] == `EAIC_REEVAL_LINE0);
    assign reev1 = wr_reev && (reg_req_i.wdata[1:0] == `EAIC_REEVAL_LINE1);

    assign unforce_condition_bits = wr_dclr ? wr_bits : `EAIC_RAW_RST;

    // ********************************************
    // Raw conditions
    // ********************************************
    // Sticky capture, set wins over clear
    // [RULE_11] [RULE_12] [RULE_13] [RULE_19] Raw capture
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            raw_condition_status <= `EAIC_RAW_RST;
        else if (clk_en_i)
            raw_condition_status <= (raw_condition_status & ~unforce_condition_bits)
                                    | cond_pulse_i
                                    | (wr_dset ? wr_bits : `EAIC_RAW_RST);
    end

    // ********************************************
    // Lines
    // ********************************************
    eaic_line u_line0 (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .clk_en_i   (clk_en_i),
        .set_we_i   (wr_set0),
        .clr_we_i   (wr_clr0),
        .reeval_i   (reev0),
        .wbits_i    (wr_bits),
        .raw_i      (raw_condition_status),
        .line_o     (line0)
    );

    eaic_line u_line1 (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .clk_en_i   (clk_en_i),
        .set_we_i   (wr_set1),
        .clr_we_i   (wr_clr1),
        .reeval_i   (reev1),
        .wbits_i    (wr_bits),
        .raw_i      (raw_condition_status),
        .line_o     (line1)
    );

    // Line 0 error, line 1 alarm
    // [RULE_18] Output wires
    assign fault_irq_line_o = {line1.irq, line0.irq};

    // [RULE_16] Enabled and asserted
    assign reev_status = {line1.irq & (|line1.mask), line0.irq & (|line0.mask)};

    // ********************************************
    // Read mux
    // ********************************************
    always_comb
    begin
        next_rdata = `EAIC_RDATA_RST;
        unique case (reg_req_i.addr)
            // [RULE_17] Raw readback
            `EAIC_OFF_RAW:    next_rdata[`EAIC_NCOND-1:0] = raw_condition_status;
            // [RULE_09] Masked status line 0
            `EAIC_OFF_MSTAT0: next_rdata[`EAIC_NCOND-1:0] = line0.masked;
            // [RULE_10] Masked status line 1
            `EAIC_OFF_MSTAT1: next_rdata[`EAIC_NCOND-1:0] = line1.masked;
            // [RULE_07] Enable readback line 0
            `EAIC_OFF_MASK0:  next_rdata[`EAIC_NCOND-1:0] = line0.mask;
            // [RULE_08] Enable readback line 1
            `EAIC_OFF_MASK1:  next_rdata[`EAIC_NCOND-1:0] = line1.mask;
            `EAIC_OFF_REEVAL: next_rdata[1:0] = reev_status;
            default:          next_rdata = `EAIC_RDATA_RST;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= `EAIC_RDATA_RST;
        else if (clk_en_i && reg_req_i.rd)
            reg_rdata_o <= next_rdata;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rvalid_o <= 1'b0;
        else if (clk_en_i)
            reg_rvalid_o <= reg_req_i.rd;
    end

    // ********************************************
    // Checks
    // ********************************************
    sequence s_reev0_pend;
        (clk_en_i && reev0) ##1 (clk_en_i && line0.any && !reev0);
    endsequence

    sequence s_reev1_pend;
        (clk_en_i && reev1) ##1 (clk_en_i && line1.any && !reev1);
    endsequence

    sequence s_drop_rise0;
        !fault_irq_line_o[0] ##1 fault_irq_line_o[0];
    endsequence

    sequence s_drop_rise1;
        !fault_irq_line_o[1] ##1 fault_irq_line_o[1];
    endsequence

    // [RULE_01] Set-mask line 0
    chk_set_mask0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_01]
        clk_en_i && wr_set0 |=> line0.mask == ($past(line0.mask) | $past(wr_bits)))
        else $error("set-mask 0 did not enable written bits");

    // [RULE_02] Set-mask line 1
    chk_set_mask1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_02]
        clk_en_i && wr_set1 |=> line1.mask == ($past(line1.mask) | $past(wr_bits)))
        else $error("set-mask 1 did not enable written bits");

    // [RULE_03] Line 0 cause
    chk_line0_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_03]
        $rose(fault_irq_line_o[0]) |-> $past(line0.any))
        else $error("line 0 rose with nothing pending");

    // [RULE_03] Line 0 release
    chk_line0_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_03]
        clk_en_i && !line0.any |=> !fault_irq_line_o[0])
        else $error("line 0 stayed high with nothing pending");

    // [RULE_04] Line 1 release
    chk_line1_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_04]
        clk_en_i && !line1.any |=> !fault_irq_line_o[1])
        else $error("line 1 stayed high with nothing pending");

    // [RULE_05] Clear-mask line 0
    chk_clr_mask0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_05]
        clk_en_i && wr_clr0 |=> (line0.mask & $past(wr_bits)) == `EAIC_MASK_RST)
        else $error("clear-mask 0 left an enable set");

    // [RULE_06] Clear-mask line 1
    chk_clr_mask1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_06]
        clk_en_i && wr_clr1 |=> (line1.mask & $past(wr_bits)) == `EAIC_MASK_RST)
        else $error("clear-mask 1 left an enable set");

    // [RULE_07] Readback line 0
    chk_mask0_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_07]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_MASK0
        |=> reg_rvalid_o && reg_rdata_o == {17'h0_0000, $past(line0.mask)})
        else $error("mask 0 readback wrong");

    // [RULE_10] Masked status line 1
    chk_mstat1_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_10]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_MSTAT1
        |=> reg_rdata_o == {17'h0_0000, $past(raw_condition_status) & $past(line1.mask)})
        else $error("masked status 1 wrong");

    // [RULE_12] Debug set
    chk_dbg_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_12]
        clk_en_i && wr_dset |=> (raw_condition_status & $past(wr_bits)) == $past(wr_bits))
        else $error("debug set did not force conditions");

    // [RULE_13] Debug clear
    chk_dbg_clr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_13]
        clk_en_i && wr_dclr
        |=> (raw_condition_status & $past(wr_bits) & ~$past(cond_pulse_i)) == `EAIC_RAW_RST)
        else $error("debug clear left a condition set");

    // [RULE_15] Re-evaluate line 0
    chk_reeval_line0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_15]
        s_reev0_pend |-> s_drop_rise0)
        else $error("line 0 did not re-assert after re-evaluation");

    // [RULE_15] Re-evaluate line 1
    chk_reeval_line1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_15]
        s_reev1_pend |-> s_drop_rise1)
        else $error("line 1 did not re-assert after re-evaluation");

    // [RULE_16] Re-evaluate readback
    chk_reeval_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_16]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_REEVAL
        |=> reg_rdata_o[1:0] == {$past(fault_irq_line_o[1]) & (|$past(line1.mask)),
                                 $past(fault_irq_line_o[0]) & (|$past(line0.mask))})
        else $error("re-evaluate readback wrong");

    // [RULE_17] Raw readback
    chk_raw_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_17]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_RAW
        |=> reg_rdata_o == {17'h0_0000, $past(raw_condition_status)})
        else $error("raw readback wrong");

    // [RULE_19] Raw sticky
    chk_raw_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_19]
        !(clk_en_i && wr_dclr)
        |=> (raw_condition_status & $past(raw_condition_status)) == $past(raw_condition_status))
        else $error("raw condition lost without clear");

    // [RULE_04] Line 1 cause
    chk_line1_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_04]
        $rose(fault_irq_line_o[1]) |-> $past(line1.any))
        else $error("line 1 rose with nothing pending");

    // [RULE_03] Line 0 follows
    chk_line0_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_03]
        clk_en_i && line0.any && !reev0 |=> fault_irq_line_o[0])
        else $error("line 0 low with a condition pending");

    // [RULE_04] Line 1 follows
    chk_line1_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_04]
        clk_en_i && line1.any && !reev1 |=> fault_irq_line_o[1])
        else $error("line 1 low with a condition pending");

    // [RULE_05] Clear keeps others line 0
    chk_clr_keep0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_05]
        clk_en_i && wr_clr0 |=> line0.mask == ($past(line0.mask) & ~$past(wr_bits)))
        else $error("clear-mask 0 disturbed other enables");

    // [RULE_06] Clear keeps others line 1
    chk_clr_keep1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_06]
        clk_en_i && wr_clr1 |=> line1.mask == ($past(line1.mask) & ~$past(wr_bits)))
        else $error("clear-mask 1 disturbed other enables");

    // [RULE_08] Readback line 1
    chk_mask1_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_08]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_MASK1
        |=> reg_rvalid_o && reg_rdata_o == {17'h0_0000, $past(line1.mask)})
        else $error("mask 1 readback wrong");

    // [RULE_09] Masked status line 0
    chk_mstat0_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_09]
        clk_en_i && reg_req_i.rd && reg_req_i.addr == `EAIC_OFF_MSTAT0
        |=> reg_rdata_o == {17'h0_0000, $past(raw_condition_status) & $past(line0.mask)})
        else $error("masked status 0 wrong");

    // [RULE_11] Frame failure bit
    chk_frame_bit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_11]
        clk_en_i && cond_pulse_i[`EAIC_BIT_FRAME_FAIL] |=> raw_condition_status[`EAIC_BIT_FRAME_FAIL])
        else $error("frame failure not captured in bit 0");

    // [RULE_14] Drop of line 0
    chk_reeval_drop0: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_14]
        clk_en_i && reev0 |=> !fault_irq_line_o[0])
        else $error("line 0 did not drop on re-evaluation");

    // [RULE_14] Drop of line 1
    chk_reeval_drop1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_14]
        clk_en_i && reev1 |=> !fault_irq_line_o[1])
        else $error("line 1 did not drop on re-evaluation");

    // [RULE_14] Other codes ignored
    chk_reeval_ignore: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_14]
        clk_en_i && wr_reev && reg_req_i.wdata[1] && line0.any && line1.any
        |=> fault_irq_line_o == 2'h3)
        else $error("unused re-evaluate code dropped a line");

    // [RULE_17] Pulse captured
    chk_raw_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_17]
        clk_en_i && (|cond_pulse_i)
        |=> (raw_condition_status & $past(cond_pulse_i)) == $past(cond_pulse_i))
        else $error("condition pulse not captured");

    // [RULE_19] Frozen while disabled
    chk_raw_freeze: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_19]
        !clk_en_i
        |=> raw_condition_status == $past(raw_condition_status) && line0.mask == $past(line0.mask))
        else $error("state moved while clock enable low");

    // [RULE_07] Read answer timing
    chk_read_valid: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // [RULE_07]
        clk_en_i |=> reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read valid not one cycle after read");

endmodule // eaic_top

`default_nettype wire

// File: hw/eaic_defines.svh
// Purpose: Constants for the error/alarm interrupt controller
// Assumes: Byte addresses on a 32-bit register port
// Notes:   Included by the package and the design files
//
// Overview of operation
// [RULE_01] A one written to set-mask 0 enables that condition on line 0
// [RULE_02] A one written to set-mask 1 enables that condition on line 1
// [RULE_03] Line 0 is high only while an enabled condition has occurred
// [RULE_04] Line 1 is high only while an enabled condition has occurred
// [RULE_05] A one written to clear-mask 0 disables that condition on line 0
// [RULE_06] A one written to clear-mask 1 disables that condition on line 1
// [RULE_07] Mask readback 0 returns line 0 enables, one meaning enabled
// [RULE_08] Mask readback 1 returns line 1 enables, one meaning enabled
// [RULE_09] Masked status 0 shows occurred and enabled conditions in bits 14..0
// [RULE_10] Masked status 1 shows occurred and enabled conditions in bits 14..0
// [RULE_11] Bit 0 of each condition field is the system-timer frame failure
// [RULE_12] A one written to debug set forces that condition to occurred
// [RULE_13] A one written to debug clear clears that forced condition
// [RULE_14] Re-evaluate write: value 00 selects line 0, 01 selects line 1
// [RULE_15] On re-evaluation the line asserts again if anything enabled is pending
// [RULE_16] Re-evaluate read: bit 0 line 0 enabled and high, bit 1 line 1
// [RULE_17] Raw status shows every occurred condition regardless of masks
// [RULE_18] Conditions go out on two wires: line 0 error, line 1 alarm
// [RULE_19] Raw bits are sticky until cleared; masks reset to zero
`ifndef EAIC_DEFINES_SVH
`define EAIC_DEFINES_SVH

`define EAIC_NCOND          15
`define EAIC_AW             8
`define EAIC_DW             32

`define EAIC_OFF_RAW        8'h00
`define EAIC_OFF_MSTAT0     8'h04
`define EAIC_OFF_MSTAT1     8'h08
`define EAIC_OFF_SET0       8'h0c
`define EAIC_OFF_SET1       8'h10
`define EAIC_OFF_CLR0       8'h14
`define EAIC_OFF_CLR1       8'h18
`define EAIC_OFF_MASK0      8'h1c
`define EAIC_OFF_MASK1      8'h20
`define EAIC_OFF_DSET       8'h24
`define EAIC_OFF_DCLR       8'h28
`define EAIC_OFF_REEVAL     8'h2c

`define EAIC_REEVAL_LINE0   2'h0
`define EAIC_REEVAL_LINE1   2'h1
`define EAIC_BIT_FRAME_FAIL 0
`define EAIC_MASK_RST       15'h0000
`define EAIC_RAW_RST        15'h0000
`define EAIC_RDATA_RST      32'h0000_0000

`endif

// File: hw/eaic_pkg.sv
// Purpose: Types for the error/alarm interrupt controller
// Assumes: eaic_defines.svh on the include path
// Notes:   Carriers for register requests and per-line state
`include "eaic_defines.svh"

package eaic_pkg;

    typedef logic [`EAIC_NCOND-1:0] eaic_cond_t;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [`EAIC_AW-1:0]  addr;
        logic [`EAIC_DW-1:0]  wdata;
    } eaic_req_s;

    typedef struct packed {
        eaic_cond_t mask;
        eaic_cond_t masked;
        logic       any;
        logic       irq;
    } eaic_line_s;

endpackage

// File: hw/eaic_line.sv
// Purpose: Enable mask and output of one interrupt line
// Assumes: Strobes are one-cycle and qualified by the clock enable
// Notes:   Instantiated once per line
`timescale 1ns/1ps
`default_nettype none
`include "eaic_defines.svh"

module eaic_line
    import eaic_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       clk_en_i,
    input  wire logic       set_we_i,
    input  wire logic       clr_we_i,
    input  wire logic       reeval_i,
    input  wire eaic_cond_t wbits_i,
    input  wire eaic_cond_t raw_i,
    output eaic_line_s      line_o
);

    eaic_cond_t mask;
    logic       irq;

    // Set and clear of the enables
    // [RULE_01] [RULE_02] [RULE_05] [RULE_06] [RULE_19] Mask update
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mask <= `EAIC_MASK_RST;
        else if (clk_en_i && set_we_i)
            mask <= mask | wbits_i;
        else if (clk_en_i && clr_we_i)
            mask <= mask & ~wbits_i;
    end

    // Line drops for one cycle on re-evaluation
    // [RULE_03] [RULE_04] [RULE_15] Line drive
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq <= 1'b0;
        else if (clk_en_i)
            irq <= (|(raw_i & mask)) & ~reeval_i;
    end

    assign line_o.mask   = mask;
    // [RULE_09] [RULE_10] Masked view
    assign line_o.masked = raw_i & mask;
    assign line_o.any    = |(raw_i & mask);
    assign line_o.irq    = irq;

endmodule // eaic_line

`default_nettype wire

// File: tb/eaic_cpu_model.sv
// Purpose: Register master standing in for the processor cores
// Assumes: One request per call, launched and released on falling edges
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module eaic_cpu_model
    import eaic_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output var  eaic_req_s   req_o
);
    logic [31:0] last_rd;
    logic        last_ok;

    initial req_o = '0;

    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge core_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge core_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffff_ffff};
        last_ok = rvalid_i;
        last_rd = rdata_i;
    endtask
endmodule // eaic_cpu_model
`default_nettype wire

// File: tb/test_error_alarm_interrupt_ctrl.sv
// Purpose: Self-checking bench for the error/alarm interrupt controller
// Assumes: Inputs change on falling edges; seed 90
// Notes:   Masks and raw bits are mirrored in the bench model
`timescale 1ns/1ps
`default_nettype none
`include "eaic_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin miscompares++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module test_error_alarm_interrupt_ctrl;
    import eaic_pkg::*;
    logic        core_clk_i;
    logic        rst_b_i;
    logic        clk_en_i;
    eaic_cond_t  cond_pulse_i;
    eaic_req_s   req;
    logic [31:0] rdata;
    logic        rvalid;
    logic [1:0]  irq;
    logic [1:0]  drop;
    logic [31:0] v;
    eaic_cond_t  m0;
    eaic_cond_t  m1;
    eaic_cond_t  raw;
    int          miscompares;
    int          checked;
    logic [7:0]  wo [7] = '{`EAIC_OFF_SET0, `EAIC_OFF_SET1, `EAIC_OFF_CLR0, `EAIC_OFF_CLR1,
                            `EAIC_OFF_DSET, `EAIC_OFF_DCLR, 8'h30};

    eaic_top dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .cond_pulse_i(cond_pulse_i), .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .fault_irq_line_o(irq));
    eaic_cpu_model cpu_u (.core_clk_i(core_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    // ****************************************
    // Shared checks
    // ****************************************
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        cpu_u.rd(a);
        `CHK("rvalid", 1'b1, cpu_u.last_ok)
        `CHK("rdata", e, cpu_u.last_rd)
    endtask

    task automatic check_all();
        logic [1:0] e_irq;
        repeat (3) @(negedge core_clk_i);
        e_irq = {|(raw & m1), |(raw & m0)};
        `CHK("irq", e_irq, irq)
        rchk(`EAIC_OFF_RAW, 32'(raw));
        rchk(`EAIC_OFF_MSTAT0, 32'(raw & m0));
        rchk(`EAIC_OFF_MSTAT1, 32'(raw & m1));
        rchk(`EAIC_OFF_MASK0, 32'(m0));
        rchk(`EAIC_OFF_MASK1, 32'(m1));
        rchk(`EAIC_OFF_REEVAL, 32'({e_irq[1] && |m1, e_irq[0] && |m0}));
    endtask

    task automatic pulse(input eaic_cond_t p);
        @(negedge core_clk_i);
        cond_pulse_i = p;
        raw |= p;
        @(negedge core_clk_i);
        cond_pulse_i = '0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        #800000;
        miscompares++;
        wrap_up();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_b_i = 1'b0;
        clk_en_i = 1'b1;
        cond_pulse_i = '0;
        m0 = '0;
        m1 = '0;
        raw = '0;
        miscompares = 0;
        checked = 0;
        void'($urandom(90));
        repeat (2) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        check_all();
        foreach (wo[i]) rchk(wo[i], 32'h0);
        repeat (4)
        begin
            v = $urandom; cpu_u.wr(`EAIC_OFF_SET0, v); m0 |= v[14:0];
            v = $urandom; cpu_u.wr(`EAIC_OFF_SET1, v); m1 |= v[14:0];
            v = $urandom; pulse(v[14:0]);
            check_all();
            v = $urandom; cpu_u.wr(`EAIC_OFF_CLR0, v); m0 &= ~v[14:0];
            v = $urandom; cpu_u.wr(`EAIC_OFF_CLR1, v); m1 &= ~v[14:0];
            v = $urandom; cpu_u.wr(`EAIC_OFF_DSET, v); raw |= v[14:0];
            check_all();
            v = $urandom; cpu_u.wr(`EAIC_OFF_DCLR, v); raw &= ~v[14:0];
            check_all();
        end
        // Frame failure on bit 0 alone reaches line 0 only
        cpu_u.wr(`EAIC_OFF_DCLR, 32'h7fff); raw = '0;
        cpu_u.wr(`EAIC_OFF_CLR0, 32'h7fff); m0 = '0;
        cpu_u.wr(`EAIC_OFF_CLR1, 32'h7fff); m1 = '0;
        check_all();
        cpu_u.wr(`EAIC_OFF_SET0, 32'h1); m0 = 15'h1;
        pulse(15'h1);
        check_all();
        // Writes are ignored while the clock enable is low
        clk_en_i = 1'b0;
        cpu_u.wr(`EAIC_OFF_SET1, 32'h7fff);
        clk_en_i = 1'b1;
        check_all();
        // Re-evaluation of each line code and the ignored codes
        cpu_u.wr(`EAIC_OFF_SET1, 32'h1); m1 = 15'h1;
        check_all();
        for (int s = 0; s < 4; s++)
        begin
            drop = 2'b00;
            cpu_u.wr(`EAIC_OFF_REEVAL, 32'(s));
            drop |= ~irq;
            @(negedge core_clk_i);
            drop |= ~irq;
            `CHK("reeval drop", (s == 0) ? 2'b01 : (s == 1) ? 2'b10 : 2'b00, drop)
            check_all();
        end
        wrap_up();
    end
endmodule // test_error_alarm_interrupt_ctrl
`undef CHK
`default_nettype wire
